/* verilog/fvrp_pkg.sv */
// fvrp_pkg: shared constants and types of the flash command sequencer
package fvrp_pkg;

    // ------------------------------------------------------------------
    // command opcodes
    // ------------------------------------------------------------------
    localparam logic [7:0] OP_VERIFY_SECTION = 8'h03;
    localparam logic [7:0] OP_READ_ONCE      = 8'h04;
    localparam logic [7:0] OP_PROGRAM_PHRASE = 8'h06;

    // ------------------------------------------------------------------
    // parameter slot indexes
    // ------------------------------------------------------------------
    localparam logic [2:0] SLOT_CMD   = 3'h0;
    localparam logic [2:0] SLOT_ADDR  = 3'h1;
    localparam logic [2:0] SLOT_COUNT = 3'h2;
    localparam logic [2:0] SLOT_WORD0 = 3'h2;
    localparam logic [2:0] SLOT_WORD3 = 3'h5;
    localparam int         NUM_SLOTS  = 6;

    // ------------------------------------------------------------------
    // address map
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 23;
    localparam int          BOUNDARY_LSB   = 17;
    localparam logic [15:0] ONCE_INDEX_MAX = 16'h0007;
    localparam logic [2:0]  PHRASE_ALIGN   = 3'h0;
    localparam int          PHRASE_WORDS   = 4;

    // ------------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------------
    localparam logic [15:0] PARAM_RESET = 16'h0000;
    localparam int          PROG_TIME_NS = 20000;
    localparam int          CLK_PERIOD_NS = 20;
    localparam int          PROG_CYCLES =
        (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          PROG_CNT_W = 10;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        FVRP_IDLE,
        FVRP_VERIFY,
        FVRP_READ,
        FVRP_PROGRAM,
        FVRP_READBACK,
        FVRP_DONE
    } fvrp_state_t;

endpackage

/* verilog/fvrp_array_if.sv */
// fvrp_array_if: word access path between sequencer and array port
`timescale 1ns/100ps
`default_nettype none
interface fvrp_array_if;
    logic        req;
    logic        wr;
    logic        info;
    logic [22:0] addr;
    logic [15:0] wdata;
    logic        ack;
    logic [15:0] rdata;
    logic        err_any;
    logic        err_unc;

    modport seq  (output req, wr, info, addr, wdata,
                  input  ack, rdata, err_any, err_unc);
    modport port (input  req, wr, info, addr, wdata,
                  output ack, rdata, err_any, err_unc);
endinterface
`default_nettype wire

/* verilog/fvrp_array_port.sv */
// fvrp_array_port: registers array pin request outputs for the sequencer; ack, read data and error inputs pass through unregistered
`timescale 1ns/100ps
`default_nettype none
module fvrp_array_port (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // sequencer side
    fvrp_array_if.port       bus,
    // array pins
    output logic             arr_req_o,
    output logic             arr_wr_o,
    output logic             arr_info_o,
    output logic [22:0]      arr_addr_o,
    output logic [15:0]      arr_wdata_o,
    input  wire logic        arr_ack_i,
    input  wire logic [15:0] arr_rdata_i,
    input  wire logic        arr_err_any_i,
    input  wire logic        arr_err_unc_i
);
    typedef struct packed {
        logic        req;
        logic        wr;
        logic        info;
        logic [22:0] addr;
        logic [15:0] wdata;
    } fvrp_port_t;

    fvrp_port_t st;
    fvrp_port_t next_st;

    always_comb begin
        next_st       = st;
        next_st.req   = bus.req & ~arr_ack_i;
        next_st.wr    = bus.wr;
        next_st.info  = bus.info;
        next_st.addr  = bus.addr;
        next_st.wdata = bus.wdata;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign arr_req_o   = st.req;
    assign arr_wr_o    = st.wr;
    assign arr_info_o  = st.info;
    assign arr_addr_o  = st.addr;
    assign arr_wdata_o = st.wdata;
    assign bus.ack     = arr_ack_i;
    assign bus.rdata   = arr_rdata_i;
    assign bus.err_any = arr_err_any_i;
    assign bus.err_unc = arr_err_unc_i;
endmodule
`default_nettype wire

/* verilog/fvrp_launch_check.sv */
// fvrp_launch_check: combinational launch-time parameter checks
`timescale 1ns/100ps
`default_nettype none
module fvrp_launch_check (
    // command parameters
    input  wire logic [15:0] slot0_i,
    input  wire logic [15:0] slot1_i,
    input  wire logic [15:0] slot2_i,
    input  wire logic [2:0]  index_i,
    // configuration
    input  wire logic        mode_allow_i,
    input  wire logic        clkdiv_ok_i,
    input  wire logic [6:0]  pflash_lo_i,
    input  wire logic [6:0]  pflash_hi_i,
    input  wire logic [22:0] prot_lo_i,
    input  wire logic [22:0] prot_hi_i,
    input  wire logic        prot_en_i,
    // results
    output logic             acc_err_o,
    output logic             prot_err_o
);
    logic [7:0]  opcode;
    logic [22:0] gaddr;
    logic [23:0] last_addr;
    logic        addr_bad;
    logic        misaligned;
    logic        crosses;
    logic        known;

    always_comb begin
        opcode     = slot0_i[15:8];
        gaddr      = {slot0_i[6:0], slot1_i};
        addr_bad   = (slot0_i[6:0] < pflash_lo_i) || (slot0_i[6:0] > pflash_hi_i);
        misaligned = gaddr[2:0] != fvrp_pkg::PHRASE_ALIGN;
        last_addr  = {1'b0, gaddr} + {5'h00, slot2_i, 3'h0} - 24'h00_0001;
        // phrase count 0 checks nothing, treated as no crossing
        crosses    = (slot2_i != 16'h0000) &&
                     (last_addr[23:fvrp_pkg::BOUNDARY_LSB] !=
                      {1'b0, gaddr[22:fvrp_pkg::BOUNDARY_LSB]});
        known      = 1'b1;
        acc_err_o  = 1'b0;
        prot_err_o = 1'b0;
        if (opcode == fvrp_pkg::OP_VERIFY_SECTION) begin
            acc_err_o = (index_i != fvrp_pkg::SLOT_COUNT)
                      | addr_bad
                      | misaligned
                      | crosses;
        end else if (opcode == fvrp_pkg::OP_READ_ONCE) begin
            acc_err_o = (index_i != fvrp_pkg::SLOT_ADDR)
                      | (slot1_i > fvrp_pkg::ONCE_INDEX_MAX);
        end else if (opcode == fvrp_pkg::OP_PROGRAM_PHRASE) begin
            acc_err_o  = (index_i != fvrp_pkg::SLOT_WORD3)
                       | addr_bad
                       | misaligned
                       | ~clkdiv_ok_i;
            prot_err_o = ~acc_err_o & prot_en_i &&
                         gaddr >= prot_lo_i && gaddr <= prot_hi_i;
        end else begin
            known = 1'b0;
        end
        if (!known || !mode_allow_i) begin
            acc_err_o = 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verilog/fvrp_sequencer.sv */
// fvrp_sequencer: verify, read-once and phrase-program command sequencer
`timescale 1ns/100ps
`default_nettype none
module fvrp_sequencer (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // parameter register access
    input  wire logic        param_wr_i,
    input  wire logic [15:0] param_wdata_i,
    input  wire logic        index_wr_i,
    input  wire logic [2:0]  index_wdata_i,
    input  wire logic        launch_i,
    input  wire logic        clear_acc_err_i,
    input  wire logic        clear_prot_viol_i,
    // configuration
    input  wire logic        mode_allow_i,
    input  wire logic        clkdiv_ok_i,
    input  wire logic [6:0]  pflash_lo_i,
    input  wire logic [6:0]  pflash_hi_i,
    input  wire logic [22:0] prot_lo_i,
    input  wire logic [22:0] prot_hi_i,
    input  wire logic        prot_en_i,
    input  wire logic [22:0] once_base_i,
    // ordinary read path
    input  wire logic        cpu_rd_i,
    input  wire logic [22:0] cpu_addr_i,
    input  wire logic [15:0] cpu_arr_data_i,
    // status
    output logic             cmd_complete_flag_o,
    output logic             access_error_flag_o,
    output logic             protect_violation_flag_o,
    output logic             verify_any_error_o,
    output logic             verify_uncorrectable_error_o,
    output logic [2:0]       param_index_ptr_o,
    output logic [15:0]      param_rdata_o,
    output logic [15:0]      cpu_rdata_o,
    // array pins
    output logic             arr_req_o,
    output logic             arr_wr_o,
    output logic             arr_info_o,
    output logic [22:0]      arr_addr_o,
    output logic [15:0]      arr_wdata_o,
    input  wire logic        arr_ack_i,
    input  wire logic [15:0] arr_rdata_i,
    input  wire logic        arr_err_any_i,
    input  wire logic        arr_err_unc_i
);
    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        fvrp_pkg::fvrp_state_t  state;
        logic [5:0][15:0]       cmd_param_regs;
        logic [2:0]             index;
        logic                   complete;
        logic                   acc_err;
        logic                   prot_viol;
        logic                   any_err;
        logic                   unc_err;
        logic [22:0]            addr;
        logic [15:0]            remain;
        logic [1:0]             word;
        logic                   req;
        logic                   wr;
        logic                   info;
        logic [fvrp_pkg::PROG_CNT_W-1:0] wait_cnt;
        logic [15:0]            rdata;
        logic [15:0]            cpu_rdata;
    } fvrp_seq_t;

    fvrp_seq_t st;
    fvrp_seq_t next_st;

    logic acc_err_chk;
    logic prot_err_chk;
    logic read_once_busy;

    fvrp_array_if arr ();

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    fvrp_launch_check u_check (
        .slot0_i      (st.cmd_param_regs[0]),
        .slot1_i      (st.cmd_param_regs[1]),
        .slot2_i      (st.cmd_param_regs[2]),
        .index_i      (st.index),
        .mode_allow_i (mode_allow_i),
        .clkdiv_ok_i  (clkdiv_ok_i),
        .pflash_lo_i  (pflash_lo_i),
        .pflash_hi_i  (pflash_hi_i),
        .prot_lo_i    (prot_lo_i),
        .prot_hi_i    (prot_hi_i),
        .prot_en_i    (prot_en_i),
        .acc_err_o    (acc_err_chk),
        .prot_err_o   (prot_err_chk)
    );

    fvrp_array_port u_port (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .bus           (arr.port),
        .arr_req_o     (arr_req_o),
        .arr_wr_o      (arr_wr_o),
        .arr_info_o    (arr_info_o),
        .arr_addr_o    (arr_addr_o),
        .arr_wdata_o   (arr_wdata_o),
        .arr_ack_i     (arr_ack_i),
        .arr_rdata_i   (arr_rdata_i),
        .arr_err_any_i (arr_err_any_i),
        .arr_err_unc_i (arr_err_unc_i)
    );

    assign arr.req   = st.req;
    assign arr.wr    = st.wr;
    assign arr.info  = st.info;
    assign arr.addr  = st.addr + {20'h0_0000, st.word, 1'b0};
    assign arr.wdata = st.cmd_param_regs[fvrp_pkg::SLOT_WORD0 + {1'b0, st.word}];

    // block-wide read blocking while read-once runs
    assign read_once_busy = (st.state == fvrp_pkg::FVRP_READ);

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        next_st = st;

        if (cpu_rd_i) begin
            next_st.cpu_rdata = read_once_busy ? 16'hFFFF : cpu_arr_data_i;
        end

        if (clear_acc_err_i) begin
            next_st.acc_err = 1'b0;
        end
        if (clear_prot_viol_i) begin
            next_st.prot_viol = 1'b0;
        end

        case (st.state)
            fvrp_pkg::FVRP_IDLE: begin
                if (param_wr_i) begin
                    next_st.cmd_param_regs[st.index] = param_wdata_i;
                end
                if (index_wr_i) begin
                    next_st.index = index_wdata_i;
                end
                if (launch_i && st.complete) begin
                    next_st.complete = 1'b0;
                    next_st.any_err  = 1'b0;
                    next_st.unc_err  = 1'b0;
                    next_st.word     = 2'h0;
                    if (acc_err_chk || prot_err_chk) begin
                        next_st.acc_err   = acc_err_chk;
                        next_st.prot_viol = prot_err_chk;
                        next_st.state     = fvrp_pkg::FVRP_DONE;
                    end else if (st.cmd_param_regs[0][15:8] == fvrp_pkg::OP_VERIFY_SECTION) begin
                        next_st.addr   = {st.cmd_param_regs[0][6:0], st.cmd_param_regs[1]};
                        next_st.remain = st.cmd_param_regs[2];
                        next_st.state  = fvrp_pkg::FVRP_VERIFY;
                        next_st.req    = st.cmd_param_regs[2] != 16'h0000;
                        next_st.wr     = 1'b0;
                        next_st.info   = 1'b0;
                        if (st.cmd_param_regs[2] == 16'h0000) begin
                            next_st.state = fvrp_pkg::FVRP_DONE;
                        end
                    end else if (st.cmd_param_regs[0][15:8] == fvrp_pkg::OP_READ_ONCE) begin
                        next_st.addr  = once_base_i + {17'h00000, st.cmd_param_regs[1][2:0], 3'h0};
                        next_st.state = fvrp_pkg::FVRP_READ;
                        next_st.req   = 1'b1;
                        next_st.wr    = 1'b0;
                        next_st.info  = 1'b1;
                    end else begin
                        next_st.addr  = {st.cmd_param_regs[0][6:0], st.cmd_param_regs[1]};
                        next_st.state = fvrp_pkg::FVRP_PROGRAM;
                        next_st.req   = 1'b1;
                        next_st.wr    = 1'b1;
                        next_st.info  = 1'b0;
                    end
                end
            end
            fvrp_pkg::FVRP_VERIFY: begin
                if (arr.ack) begin
                    next_st.req = 1'b0;
                    if (arr_rdata_i != 16'hFFFF || arr.err_any) begin
                        next_st.any_err = 1'b1;
                    end
                    if (arr.err_unc) begin
                        next_st.unc_err = 1'b1;
                    end
                    next_st.word = st.word + 2'h1;
                    if (st.word == 2'h3) begin
                        next_st.remain = st.remain - 16'h0001;
                        next_st.addr   = st.addr + 23'h000008;
                        if (st.remain == 16'h0001) begin
                            next_st.state = fvrp_pkg::FVRP_DONE;
                        end
                    end
                end else if (!st.req) begin
                    next_st.req = 1'b1;
                end
            end
            fvrp_pkg::FVRP_READ: begin
                if (arr.ack) begin
                    next_st.req = 1'b0;
                    next_st.cmd_param_regs[fvrp_pkg::SLOT_WORD0 + {1'b0, st.word}] = arr.rdata;
                    next_st.any_err = st.any_err | arr.err_any;
                    next_st.unc_err = st.unc_err | arr.err_unc;
                    next_st.word    = st.word + 2'h1;
                    if (st.word == 2'h3) begin
                        next_st.state = fvrp_pkg::FVRP_DONE;
                    end
                end else if (!st.req) begin
                    next_st.req = 1'b1;
                end
            end
            fvrp_pkg::FVRP_PROGRAM: begin
                if (arr.ack) begin
                    next_st.req      = 1'b0;
                    next_st.word     = st.word + 2'h1;
                    next_st.wait_cnt = fvrp_pkg::PROG_CNT_W'(fvrp_pkg::PROG_CYCLES);
                    if (st.word == 2'h3) begin
                        next_st.state = fvrp_pkg::FVRP_READBACK;
                        next_st.wr    = 1'b0;
                    end
                end else if (!st.req) begin
                    if (st.wait_cnt != '0) begin
                        next_st.wait_cnt = st.wait_cnt - 1'b1;
                    end else begin
                        next_st.req = 1'b1;
                    end
                end
            end
            fvrp_pkg::FVRP_READBACK: begin
                if (arr.ack) begin
                    next_st.req = 1'b0;
                    if (arr.rdata != st.cmd_param_regs[fvrp_pkg::SLOT_WORD0 + {1'b0, st.word}]
                        || arr.err_any) begin
                        next_st.any_err = 1'b1;
                    end
                    if (arr.err_unc) begin
                        next_st.unc_err = 1'b1;
                    end
                    next_st.word = st.word + 2'h1;
                    if (st.word == 2'h3) begin
                        next_st.state = fvrp_pkg::FVRP_DONE;
                    end
                end else if (!st.req) begin
                    next_st.req = 1'b1;
                end
            end
            fvrp_pkg::FVRP_DONE: begin
                next_st.complete = 1'b1;
                next_st.req      = 1'b0;
                next_st.state    = fvrp_pkg::FVRP_IDLE;
            end
            default: begin
                next_st.state = fvrp_pkg::FVRP_IDLE;
            end
        endcase
        next_st.rdata = next_st.cmd_param_regs[next_st.index];
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st          <= '0;
            st.state    <= fvrp_pkg::FVRP_IDLE;
            st.complete <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign cmd_complete_flag_o          = st.complete;
    assign access_error_flag_o          = st.acc_err;
    assign protect_violation_flag_o     = st.prot_viol;
    assign verify_any_error_o           = st.any_err;
    assign verify_uncorrectable_error_o = st.unc_err;
    assign param_index_ptr_o            = st.index;
    assign param_rdata_o                = st.rdata;
    assign cpu_rdata_o                  = st.cpu_rdata;
endmodule
`default_nettype wire

/* bench/fvrp_seq_monitor.sv */
// fvrp_seq_monitor: port assertions for the command sequencer
`timescale 1ns/100ps
`default_nettype none
module fvrp_seq_monitor (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        launch_i,
    input wire logic        clear_acc_err_i,
    input wire logic        mode_allow_i,
    input wire logic        cpu_rd_i,
    input wire logic        arr_ack_i,
    input wire logic        cmd_complete_flag_o,
    input wire logic        access_error_flag_o,
    input wire logic        protect_violation_flag_o,
    input wire logic        verify_any_error_o,
    input wire logic        verify_uncorrectable_error_o,
    input wire logic        arr_req_o,
    input wire logic        arr_info_o,
    input wire logic [15:0] cpu_rdata_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_launch;
        launch_i && cmd_complete_flag_o;
    endsequence
    sequence s_fast_done;
        ##1 cmd_complete_flag_o && access_error_flag_o;
    endsequence
    property p_launch_busy;
        s_launch |=> !cmd_complete_flag_o;
    endproperty
    property p_mode_fail;
        s_launch ##0 !mode_allow_i |=> s_fast_done;
    endproperty
    property p_req_hold;
        arr_req_o && !arr_ack_i |=> arr_req_o;
    endproperty
    property p_idle_quiet;
        cmd_complete_flag_o && !$rose(cmd_complete_flag_o) |-> !arr_req_o;
    endproperty
    property p_once_hide;
        arr_req_o && arr_info_o && cpu_rd_i |=> cpu_rdata_o == 16'hffff;
    endproperty
    property p_prot_at_end;
        $rose(protect_violation_flag_o) |=> $rose(cmd_complete_flag_o);
    endproperty
    property p_acc_at_end;
        $rose(access_error_flag_o) |=> $rose(cmd_complete_flag_o);
    endproperty
    property p_unc_any;
        $rose(verify_uncorrectable_error_o) |-> verify_any_error_o;
    endproperty
    property p_clear;
        clear_acc_err_i && cmd_complete_flag_o && !launch_i |=> !access_error_flag_o;
    endproperty
    a_launch_busy: assert property (p_launch_busy)
        else $error("complete flag high after launch");
    a_mode_fail: assert property (p_mode_fail)
        else $error("disallowed command not refused promptly");
    a_req_hold: assert property (p_req_hold)
        else $error("array request dropped before ack");
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("array request while idle");
    a_once_hide: assert property (p_once_hide)
        else $error("array data visible during read-once");
    a_prot_at_end: assert property (p_prot_at_end)
        else $error("protection flag set away from completion");
    a_acc_at_end: assert property (p_acc_at_end)
        else $error("access error set away from completion");
    a_unc_any: assert property (p_unc_any)
        else $error("lower status bit without upper");
    a_clear: assert property (p_clear)
        else $error("access error not cleared");
endmodule
bind fvrp_sequencer fvrp_seq_monitor fvrp_seq_monitor_inst (.clk_i, .rst_i, .launch_i,
    .clear_acc_err_i, .mode_allow_i, .cpu_rd_i, .arr_ack_i, .cmd_complete_flag_o,
    .access_error_flag_o, .protect_violation_flag_o, .verify_any_error_o,
    .verify_uncorrectable_error_o, .arr_req_o, .arr_info_o, .cpu_rdata_o);
`default_nettype wire

/* bench/testbench.sv */
// testbench: directed tests of the command sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    localparam logic [22:0] ONCE_BASE = 23'h00_0100;
    logic        clk_i = 1'b0, rst_i = 1'b1, param_wr_i = 1'b0, index_wr_i = 1'b0;
    logic        launch_i = 1'b0, clear_acc_err_i = 1'b0, clear_prot_viol_i = 1'b0;
    logic        mode_allow_i = 1'b1, clkdiv_ok_i = 1'b1, prot_en_i = 1'b0, cpu_rd_i = 1'b1;
    logic        arr_ack_i = 1'b0, arr_err_any_i = 1'b0, arr_err_unc_i = 1'b0, inj = 1'b0;
    logic [15:0] param_wdata_i = 16'h0000, arr_rdata_i = 16'h0000, tick = 16'h0000;
    logic [2:0]  index_wdata_i = 3'h0;
    logic        cmd_complete_flag_o, access_error_flag_o, protect_violation_flag_o;
    logic        verify_any_error_o, verify_uncorrectable_error_o, arr_req_o, arr_wr_o;
    logic        arr_info_o;
    logic [2:0]  param_index_ptr_o;
    logic [15:0] param_rdata_o, cpu_rdata_o, arr_wdata_o;
    logic [22:0] arr_addr_o;
    logic [15:0] mem [4] = '{4{16'hffff}};
    int          mismatches = 0, check_count = 0, cycles = 0;
    fvrp_sequencer fvrp_sequencer_inst (.clk_i, .rst_i, .param_wr_i, .param_wdata_i,
        .index_wr_i, .index_wdata_i, .launch_i, .clear_acc_err_i, .clear_prot_viol_i,
        .mode_allow_i, .clkdiv_ok_i, .pflash_lo_i(7'h00), .pflash_hi_i(7'h03),
        .prot_lo_i(23'h03_0000), .prot_hi_i(23'h03_ffff), .prot_en_i,
        .once_base_i(ONCE_BASE), .cpu_rd_i, .cpu_addr_i({7'h00, tick}), .cpu_arr_data_i(tick),
        .cmd_complete_flag_o, .access_error_flag_o, .protect_violation_flag_o,
        .verify_any_error_o, .verify_uncorrectable_error_o, .param_index_ptr_o,
        .param_rdata_o, .cpu_rdata_o, .arr_req_o, .arr_wr_o, .arr_info_o, .arr_addr_o,
        .arr_wdata_o, .arr_ack_i, .arr_rdata_i, .arr_err_any_i, .arr_err_unc_i);
    always #10 clk_i = ~clk_i;
    // array stand-in: one ack per request, info space returns its address
    always @(posedge clk_i) begin
        tick <= tick + 16'h0001;
        cycles++;
        if (cycles > 60000) begin
            mismatches++;
            tally_and_finish();
        end
        arr_ack_i <= arr_req_o && !arr_ack_i;
        arr_err_any_i <= inj;
        arr_err_unc_i <= inj;
        if (arr_req_o && !arr_ack_i && arr_wr_o) mem[arr_addr_o[2:1]] <= arr_wdata_o;
        arr_rdata_i <= arr_info_o ? arr_addr_o[15:0] : mem[arr_addr_o[2:1]];
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [2:0] idx, input logic [15:0] val, input logic wr);
        @(posedge clk_i);
        index_wr_i <= 1'b1;
        index_wdata_i <= idx;
        @(posedge clk_i);
        index_wr_i <= 1'b0;
        param_wr_i <= wr;
        param_wdata_i <= val;
        @(posedge clk_i);
        param_wr_i <= 1'b0;
    endtask
    task automatic peek(input logic [2:0] idx, input logic [15:0] exp);
        put(idx, 16'h0000, 1'b0);
        @(posedge clk_i);
        #1 chk(param_rdata_o, exp);
        chk({13'h0000, param_index_ptr_o}, {13'h0000, idx});
    endtask
    // flags seen as {access, protect, any, uncorrectable}
    task automatic run(input logic [15:0] s0, s1, s2, input logic [2:0] ptr,
                       input logic [3:0] exp);
        int n;
        @(posedge clk_i);
        clear_acc_err_i <= 1'b1;
        clear_prot_viol_i <= 1'b1;
        @(posedge clk_i);
        clear_acc_err_i <= 1'b0;
        clear_prot_viol_i <= 1'b0;
        put(3'h0, s0, 1'b1);
        put(3'h1, s1, 1'b1);
        for (n = 2; n < 6; n++) put(n[2:0], s2 + 16'(n - 2), 1'b1);
        put(ptr, 16'h0000, 1'b0);
        launch_i <= 1'b1;
        @(posedge clk_i);
        launch_i <= 1'b0;
        #1 chk({15'h0000, cmd_complete_flag_o}, 16'h0000);
        while (cmd_complete_flag_o !== 1'b1) @(posedge clk_i) #1;
        #1 chk({12'h000, access_error_flag_o, protect_violation_flag_o, verify_any_error_o,
                verify_uncorrectable_error_o}, {12'h000, exp});
    endtask
    task automatic t_verify();
        @(posedge clk_i) prot_en_i <= 1'b1;
        run(16'h0301, 16'h0000, 16'h0002, 3'h2, 4'b0000);
        run(16'h0303, 16'h0000, 16'h0001, 3'h2, 4'b0000);
        run(16'h0301, 16'h0000, 16'h0002, 3'h1, 4'b1000);
        run(16'h0301, 16'h0004, 16'h0002, 3'h2, 4'b1000);
        run(16'h0301, 16'hfff8, 16'h0002, 3'h2, 4'b1000);
        run(16'h0301, 16'hfff8, 16'h0001, 3'h2, 4'b0000);
        run(16'h0310, 16'h0000, 16'h0002, 3'h2, 4'b1000);
        @(posedge clk_i) inj <= 1'b1;
        run(16'h0301, 16'h0000, 16'h0001, 3'h2, 4'b0011);
        @(posedge clk_i) inj <= 1'b0;
        $display("section verify done");
    endtask
    task automatic t_once();
        int w;
        run(16'h0400, 16'h0003, 16'h0000, 3'h1, 4'b0000);
        for (w = 0; w < 4; w++) peek(3'(w + 2), ONCE_BASE[15:0] + 16'(24 + 2 * w));
        run(16'h0400, 16'h0008, 16'h0000, 3'h1, 4'b1000);
        run(16'h0400, 16'h0003, 16'h0000, 3'h2, 4'b1000);
        $display("read once done");
    endtask
    task automatic t_mode();
        @(posedge clk_i) mode_allow_i <= 1'b0;
        run(16'h0301, 16'h0000, 16'h0001, 3'h2, 4'b1000);
        run(16'h0400, 16'h0001, 16'h0000, 3'h1, 4'b1000);
        run(16'h0601, 16'h0000, 16'h1234, 3'h5, 4'b1000);
        @(posedge clk_i) mode_allow_i <= 1'b1;
        $display("mode refusal done");
    endtask
    task automatic t_program();
        int w;
        run(16'h0601, 16'h0000, 16'h1234, 3'h4, 4'b1000);
        run(16'h0601, 16'h0002, 16'h1234, 3'h5, 4'b1000);
        run(16'h0603, 16'h0000, 16'h1234, 3'h5, 4'b0100);
        @(posedge clk_i) clkdiv_ok_i <= 1'b0;
        run(16'h0601, 16'h0000, 16'h1234, 3'h5, 4'b1000);
        @(posedge clk_i) clkdiv_ok_i <= 1'b1;
        run(16'h0601, 16'h0008, 16'ha5a0, 3'h5, 4'b0000);
        for (w = 0; w < 4; w++) chk(mem[w], 16'ha5a0 + 16'(w));
        $display("phrase program done");
    endtask
    task automatic tally_and_finish();
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_verify();
        t_once();
        t_mode();
        t_program();
        tally_and_finish();
    end
endmodule
`default_nettype wire
